// >>> rtl/ebat_map.vh
// Constants for the external bus acknowledge termination block
`ifndef EBAT_MAP_VH
`define EBAT_MAP_VH

// ==========================================================
// Clocking
`define EBAT_CLK_PERIOD_NS  50
`define EBAT_BUS_DIV        2
`define EBAT_BUS_PERIOD_NS  (`EBAT_CLK_PERIOD_NS * `EBAT_BUS_DIV)

// ==========================================================
// Timeout, in system bus clock cycles
`define EBAT_TMO_BUS_CYC    11'h400
`define EBAT_TMO_LAST       11'h3ff
`define EBAT_TMO_W          11

// ==========================================================
// Mode qualification
`define EBAT_EDGE_CS        3'h5
`define EBAT_LVL_EXCL_CS    3'h4
`define EBAT_EDGE_WSC       6'h3f
`define EBAT_LVL_WSC_MIN    6'h01
`define EBAT_LVL_CSN_LIM    4'h3
`define EBAT_INS_BASE       3'h2

// ==========================================================
// Acknowledge modes
`define EBAT_MODE_PLAIN     2'h0
`define EBAT_MODE_EDGE      2'h1
`define EBAT_MODE_LEVEL     2'h2

// ==========================================================
// Reset values
`define EBAT_ADDR_RST       24'h000000
`define EBAT_CS_N_RST       6'h3f
`define EBAT_BE_N_RST       4'hf

`endif

// >>> rtl/ebat_top.v
// External bus cycle sequencer with transfer acknowledge termination
`timescale 1ns/10ps
`default_nettype none
`include "ebat_map.vh"

module ebat_top (
  input  wire        CLK_I,
  input  wire        RST_N_I,
  input  wire        REQ_I,
  input  wire [2:0]  CS_SEL_I,
  input  wire        WR_I,
  input  wire [23:0] ADDR_I,
  input  wire [3:0]  BE_I,
  input  wire [5:0]  WAIT_STATE_COUNT_I,
  input  wire [3:0]  CS_ASSERT_DELAY_I,
  input  wire [3:0]  CS_NEGATE_DELAY_I,
  input  wire        ACK_GATE_ENABLE_I,
  input  wire [1:0]  ACK_INSENSITIVITY_TIME_I,
  input  wire        EXT_WAIT_ENABLE_I,
  input  wire        SYNC_BURST_I,
  input  wire        OE_ON_FALL_I,
  input  wire        BE_ON_FALL_I,
  input  wire        BCLK_ON_FALL_I,
  input  wire        TRANSFER_ACK_IN_N_I,
  output reg         BUS_CLK_O,
  output reg  [23:0] ADDR_O,
  output reg  [5:0]  CS_N_O,
  output reg         RW_N_O,
  output reg         OE_N_O,
  output reg  [3:0]  BE_N_O,
  output reg         BCLK_O,
  output reg         BUSY_O,
  output reg         DONE_O,
  output reg         BUS_ERR_O,
  output reg  [1:0]  ACK_MODE_O,
  output reg         STALL_O
);

  // ==========================================================
  // Functions
  function [5:0] cs_dec;
    input [2:0] sel;
    begin
      cs_dec = 6'h00;
      if (sel < 3'h6) begin
        cs_dec = 6'h01 << sel;
      end
    end
  endfunction

  // ==========================================================
  // State
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_CSA  = 2'h1;
  localparam [1:0] S_DATA = 2'h2;
  localparam [1:0] S_CSN  = 2'h3;

  reg  [1:0]             state_r;
  reg                    pend_r;
  reg  [2:0]             cs_r;
  reg                    wr_r;
  reg  [23:0]            addr_r;
  reg  [3:0]             be_r;
  reg  [1:0]             mode_r;
  reg  [5:0]             ws_r;
  reg  [3:0]             dly_r;
  reg  [3:0]             csn_r;
  reg  [2:0]             ins_r;
  reg  [2:0]             ins_cfg_r;
  reg  [`EBAT_TMO_W-1:0] tmo_r;
  reg                    err_r;
  reg                    oe_req_r;
  reg                    be_req_r;
  reg                    edge_seen_r;
  reg                    ack_meta_r;
  reg                    ack_sync_r;
  reg                    ack_prev_r;

  wire fe = BUS_CLK_O;
  wire re = ~BUS_CLK_O;
  wire ack_rise = ack_sync_r & ~ack_prev_r;
  wire ack_used = (mode_r != `EBAT_MODE_PLAIN);

  // ==========================================================
  // Mode decode, sampled with the request
  reg  [1:0] mode_nxt;
  always @* begin
    mode_nxt = `EBAT_MODE_PLAIN;
    if (!SYNC_BURST_I) begin
      if (ACK_GATE_ENABLE_I && CS_SEL_I == `EBAT_EDGE_CS &&
          WAIT_STATE_COUNT_I == `EBAT_EDGE_WSC &&
          (CS_ASSERT_DELAY_I != 4'h0 || CS_NEGATE_DELAY_I != 4'h0)) begin
        mode_nxt = `EBAT_MODE_EDGE;
      end else if (!ACK_GATE_ENABLE_I && EXT_WAIT_ENABLE_I &&
                   CS_SEL_I != `EBAT_LVL_EXCL_CS &&
                   WAIT_STATE_COUNT_I > `EBAT_LVL_WSC_MIN &&
                   CS_NEGATE_DELAY_I < `EBAT_LVL_CSN_LIM) begin
        mode_nxt = `EBAT_MODE_LEVEL;
      end
    end
  end

  // ==========================================================
  // Acknowledge pin synchroniser; the pin is active low, kept as high = released
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_meta_r <= 1'b1;
      ack_sync_r <= 1'b1;
      ack_prev_r <= 1'b1;
    end else begin
      ack_meta_r <= TRANSFER_ACK_IN_N_I;
      ack_sync_r <= ack_meta_r;
      ack_prev_r <= ack_sync_r;
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  // The bus clock is CLK_I divided by two; its edges act as enables
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUS_CLK_O   <= 1'b0;
      ADDR_O      <= `EBAT_ADDR_RST;
      CS_N_O      <= `EBAT_CS_N_RST;
      RW_N_O      <= 1'b1;
      OE_N_O      <= 1'b1;
      BE_N_O      <= `EBAT_BE_N_RST;
      BCLK_O      <= 1'b0;
      BUSY_O      <= 1'b0;
      DONE_O      <= 1'b0;
      BUS_ERR_O   <= 1'b0;
      ACK_MODE_O  <= `EBAT_MODE_PLAIN;
      STALL_O     <= 1'b0;
      state_r     <= S_IDLE;
      pend_r      <= 1'b0;
      cs_r        <= 3'h0;
      wr_r        <= 1'b0;
      addr_r      <= `EBAT_ADDR_RST;
      be_r        <= 4'h0;
      mode_r      <= `EBAT_MODE_PLAIN;
      ws_r        <= 6'h00;
      dly_r       <= 4'h0;
      csn_r       <= 4'h0;
      ins_r       <= 3'h0;
      ins_cfg_r   <= 3'h0;
      tmo_r       <= {`EBAT_TMO_W{1'b0}};
      err_r       <= 1'b0;
      oe_req_r    <= 1'b0;
      be_req_r    <= 1'b0;
      edge_seen_r <= 1'b0;
    end else begin
      BUS_CLK_O <= ~BUS_CLK_O;
      DONE_O    <= 1'b0;
      BUS_ERR_O <= 1'b0;

      // Request accepted only while idle; it waits for the next falling edge
      if (REQ_I && !BUSY_O) begin
        pend_r     <= 1'b1;
        BUSY_O     <= 1'b1;
        cs_r       <= CS_SEL_I;
        wr_r       <= WR_I;
        addr_r     <= ADDR_I;
        be_r       <= BE_I;
        mode_r     <= mode_nxt;
        ACK_MODE_O <= mode_nxt;
        ws_r       <= WAIT_STATE_COUNT_I;
        dly_r      <= CS_ASSERT_DELAY_I;
        csn_r      <= CS_NEGATE_DELAY_I;
        ins_cfg_r  <= `EBAT_INS_BASE + {1'b0, ACK_INSENSITIVITY_TIME_I};
      end

      // Strobes placed on the chosen half of the bus clock
      if (OE_ON_FALL_I ? fe : re) begin
        OE_N_O <= ~oe_req_r;
      end
      if (BE_ON_FALL_I ? fe : re) begin
        BE_N_O <= be_req_r ? ~be_r : `EBAT_BE_N_RST;
      end
      if (BCLK_ON_FALL_I ? fe : re) begin
        BCLK_O <= (state_r == S_DATA) ? ~BCLK_O : 1'b0;
      end

      if (fe) begin
        case (state_r)
          S_IDLE: begin
            if (pend_r) begin
              pend_r  <= 1'b0;
              ADDR_O  <= addr_r;
              RW_N_O  <= ~wr_r;
              CS_N_O  <= ~cs_dec(cs_r);
              tmo_r   <= {`EBAT_TMO_W{1'b0}};
              err_r   <= 1'b0;
              state_r <= S_CSA;
            end
          end
          S_CSA: begin
            if (dly_r == 4'h0) begin
              oe_req_r    <= ~wr_r;
              be_req_r    <= 1'b1;
              ins_r       <= ins_cfg_r;
              edge_seen_r <= 1'b0;
              state_r     <= S_DATA;
            end else begin
              dly_r <= dly_r - 4'h1;
            end
          end
          S_DATA: begin
            if (ack_used) begin
              tmo_r <= tmo_r + {{(`EBAT_TMO_W-1){1'b0}}, 1'b1};
            end
            if (ack_used && tmo_r == `EBAT_TMO_LAST) begin
              err_r    <= 1'b1;
              oe_req_r <= 1'b0;
              be_req_r <= 1'b0;
              STALL_O  <= 1'b0;
              dly_r    <= csn_r;
              state_r  <= S_CSN;
            end else if (mode_r == `EBAT_MODE_EDGE) begin
              // Wait count is ignored: only the rising edge or the timeout ends the cycle
              if (edge_seen_r || ack_rise) begin
                oe_req_r <= 1'b0;
                be_req_r <= 1'b0;
                dly_r    <= csn_r;
                state_r  <= S_CSN;
              end
            end else if (mode_r == `EBAT_MODE_LEVEL && ins_r != 3'h0) begin
              ins_r <= ins_r - 3'h1;
            end else if (mode_r == `EBAT_MODE_LEVEL && !ack_sync_r) begin
              STALL_O <= 1'b1;
            end else begin
              STALL_O <= 1'b0;
              if (ws_r <= `EBAT_LVL_WSC_MIN) begin
                oe_req_r <= 1'b0;
                be_req_r <= 1'b0;
                dly_r    <= csn_r;
                state_r  <= S_CSN;
              end else begin
                ws_r <= ws_r - 6'h01;
              end
            end
          end
          default: begin
            // Negate delay keeps the next cycle apart so a fresh edge is needed
            if (dly_r == 4'h0) begin
              CS_N_O    <= `EBAT_CS_N_RST;
              DONE_O    <= ~err_r;
              BUS_ERR_O <= err_r;
              BUSY_O    <= 1'b0;
              state_r   <= S_IDLE;
            end else begin
              dly_r <= dly_r - 4'h1;
            end
          end
        endcase
      end

      // A rising edge landing between bus clock edges is kept; set wins
      if (state_r == S_DATA && ack_rise) begin
        edge_seen_r <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/ebat_checker.sv
// Port-level assertions for the acknowledge termination block
`timescale 1ns/10ps
`default_nettype none
module ebat_checker (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        BUS_CLK_O,
  input wire logic [23:0] ADDR_O,
  input wire logic [5:0]  CS_N_O,
  input wire logic        BUSY_O,
  input wire logic        DONE_O,
  input wire logic        BUS_ERR_O,
  input wire logic [1:0]  ACK_MODE_O,
  input wire logic        STALL_O
);
  // ==========================================================
  // Busy length, bounded by the timeout in acknowledge modes
  logic [11:0] busy_cnt_r;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) busy_cnt_r <= 12'h000;
    else if (BUSY_O) busy_cnt_r <= busy_cnt_r + 12'h001;
    else busy_cnt_r <= 12'h000;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ==========================================================
  // Assertions
  busy_bound_a: assert property (BUSY_O && ACK_MODE_O != 2'h0 |-> busy_cnt_r < 12'h8a0)
    else $error("acknowledge access outlived timeout");
  err_cs_off_a: assert property (BUS_ERR_O |-> CS_N_O == 6'h3f && !BUSY_O && !DONE_O)
    else $error("error end left cycle open");
  err_mode_a: assert property (BUS_ERR_O |-> ACK_MODE_O != 2'h0)
    else $error("timeout in plain mode");
  edge_cs_a: assert property (BUSY_O && ACK_MODE_O == 2'h1 |-> CS_N_O[4:0] == 5'h1f)
    else $error("edge mode off select five");
  level_cs_a: assert property (ACK_MODE_O == 2'h2 |-> CS_N_O[4])
    else $error("level mode on select four");
  addr_fall_a: assert property ($changed(ADDR_O) |-> $past(BUS_CLK_O))
    else $error("address moved on bus rise");
  cs_fall_a: assert property ($changed(CS_N_O) |-> $past(BUS_CLK_O))
    else $error("select moved on bus rise");
  stall_lvl_a: assert property (STALL_O |-> ACK_MODE_O == 2'h2 && BUSY_O && !DONE_O)
    else $error("stall outside level access");
  cov_done: cover property (DONE_O && ACK_MODE_O == 2'h1);
  cov_err: cover property (BUS_ERR_O);
  cov_stall: cover property ($fell(STALL_O));
endmodule
bind ebat_top ebat_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .BUS_CLK_O(BUS_CLK_O),
  .ADDR_O(ADDR_O), .CS_N_O(CS_N_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .BUS_ERR_O(BUS_ERR_O),
  .ACK_MODE_O(ACK_MODE_O), .STALL_O(STALL_O));
`default_nettype wire

// >>> verif/ebat_ext_dev.sv
// External asynchronous device answering with the acknowledge pin
`timescale 1ns/10ps
`default_nettype none
module ebat_ext_dev (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [5:0]  cs_n_i,
  input  wire logic [15:0] hold_i,
  output var  logic        ack_n_o
);
  logic [15:0] cnt_r;
  // ==========================================================
  // Low for hold_i clocks once selected; driven high by the register while no select is low
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 16'h0000;
      ack_n_o <= 1'b1;
    end else if (cs_n_i == 6'h3f) begin
      cnt_r <= 16'h0000;
      ack_n_o <= 1'b1;
    end else begin
      ack_n_o <= !(cnt_r < hold_i);
      if (cnt_r < hold_i) cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> verif/ebat_top_tb.sv
// Testbench for the acknowledge termination block
`timescale 1ns/10ps
`default_nettype none
module ebat_top_tb;
  logic        clk, rst_n, req, wr, gate, ew, sync, oe_f, be_f, bc_f, ack_n;
  logic [2:0]  cs_sel;
  logic [5:0]  wait_state_count, cs_n;
  logic [3:0]  cs_assert_delay, cs_negate_delay, be, be_n;
  logic [1:0]  ack_insensitivity_time, mode;
  logic [23:0] addr, addr_o;
  logic [15:0] hold;
  logic [30:0] cfg;
  logic [7:0]  t;
  logic        bus_clk, rw_n, oe_n, bclk, busy, done, err, stall;
  int          error_cnt, checked, cyc;
  assign {cs_sel, wait_state_count, cs_assert_delay, cs_negate_delay, gate, ack_insensitivity_time, ew, sync} = cfg;
  assign {bc_f, be_f, oe_f, wr} = t[3:0];
  assign be = 4'hf ^ t[3:0];
  assign addr = {t, 16'ha5c3};
  ebat_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .CS_SEL_I(cs_sel), .WR_I(wr), .ADDR_I(addr),
    .BE_I(be), .WAIT_STATE_COUNT_I(wait_state_count), .CS_ASSERT_DELAY_I(cs_assert_delay), .CS_NEGATE_DELAY_I(cs_negate_delay),
    .ACK_GATE_ENABLE_I(gate), .ACK_INSENSITIVITY_TIME_I(ack_insensitivity_time), .EXT_WAIT_ENABLE_I(ew), .SYNC_BURST_I(sync),
    .OE_ON_FALL_I(oe_f), .BE_ON_FALL_I(be_f), .BCLK_ON_FALL_I(bc_f), .TRANSFER_ACK_IN_N_I(ack_n),
    .BUS_CLK_O(bus_clk), .ADDR_O(addr_o), .CS_N_O(cs_n), .RW_N_O(rw_n), .OE_N_O(oe_n), .BE_N_O(be_n),
    .BCLK_O(bclk), .BUSY_O(busy), .DONE_O(done), .BUS_ERR_O(err), .ACK_MODE_O(mode), .STALL_O(stall));
  ebat_ext_dev u_dev (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .hold_i(hold), .ack_n_o(ack_n));
  // ==========================================================
  // Checking and closing
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // One request; wait for its end under a bound, then compare
  task automatic access(input logic [30:0] c, input logic [15:0] h, input logic [1:0] em,
                        input logic ee, input logic es);
    int k;
    logic st;
    st = 1'b0;
    k = 0;
    @(negedge clk);
    cfg = c;
    hold = h;
    t = t + 8'h01;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1 && err !== 1'b1 && k < 3000) begin
      @(negedge clk);
      st = st | (stall === 1'b1);
      k++;
    end
    // A hung access counts as a mismatch
    if (k >= 3000) error_cnt++;
    check({23'h0, err}, {23'h0, ee});
    check({22'h0, mode}, {22'h0, em});
    check({23'h0, st}, {23'h0, es});
    check(addr_o, addr);
    check({23'h0, rw_n}, {23'h0, ~wr});
    check({18'h0, cs_n}, 24'h00003f);
    check({20'h0, be_n}, 24'h00000f);
    check({23'h0, oe_n}, 24'h000001);
    check({23'h0, bclk}, 24'h000000);
    $display("Test %0d ended at %0t", t, $time);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // Config order: cs, wsc, csa, csn, gate, dct, ew, sync
  initial begin
    {rst_n, req, cfg, hold, t, error_cnt, checked, cyc} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    access({3'h1, 6'h03, 4'h0, 4'h1, 1'b0, 2'h0, 1'b0, 1'b0}, 16'h0000, 2'h0, 1'b0, 1'b0);
    access({3'h5, 6'h3f, 4'h1, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0}, 16'h0014, 2'h1, 1'b0, 1'b0);
    access({3'h5, 6'h3f, 4'h0, 4'h1, 1'b1, 2'h0, 1'b0, 1'b0}, 16'h0006, 2'h1, 1'b0, 1'b0);
    access({3'h3, 6'h3f, 4'h1, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0}, 16'hffff, 2'h0, 1'b0, 1'b0);
    access({3'h5, 6'h3f, 4'h0, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0}, 16'hffff, 2'h0, 1'b0, 1'b0);
    access({3'h2, 6'h02, 4'h0, 4'h0, 1'b0, 2'h1, 1'b1, 1'b0}, 16'h0004, 2'h2, 1'b0, 1'b0);
    access({3'h2, 6'h02, 4'h0, 4'h2, 1'b0, 2'h3, 1'b1, 1'b0}, 16'h0028, 2'h2, 1'b0, 1'b1);
    access({3'h4, 6'h02, 4'h0, 4'h0, 1'b0, 2'h1, 1'b1, 1'b0}, 16'h0028, 2'h0, 1'b0, 1'b0);
    access({3'h2, 6'h02, 4'h0, 4'h0, 1'b0, 2'h1, 1'b1, 1'b1}, 16'h0028, 2'h0, 1'b0, 1'b0);
    access({3'h2, 6'h02, 4'h0, 4'h3, 1'b0, 2'h1, 1'b1, 1'b0}, 16'h0028, 2'h0, 1'b0, 1'b0);
    access({3'h5, 6'h3f, 4'h1, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0}, 16'hffff, 2'h1, 1'b1, 1'b0);
    access({3'h0, 6'h02, 4'h0, 4'h0, 1'b0, 2'h0, 1'b1, 1'b0}, 16'h0002, 2'h2, 1'b0, 1'b0);
    access({3'h5, 6'h3f, 4'h1, 4'h0, 1'b1, 2'h0, 1'b0, 1'b0}, 16'h0014, 2'h1, 1'b0, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
